// ### src/zcrs_core.v
// Functional notes
// - stop word 1 stops group, 2 releases
// - upstream jam word rise starts clearing
// - downstream jam word rise starts clearing
// - held one never retriggers; needs fresh rise
// - mode 3 alternate release, 4 default
// - mode 5 run forward, 6 reverse
// - mode 7 places zones in maintenance
// - mode 10 default direction, 11 opposite
// - high byte counts zones from start
// - zone count zero addresses whole subnet
// - upstream word starts upstream, downstream downstream
// - accumulate only after clear to blocked
// - occupied zone waits for fresh arrival
// - empty zone holds next arriving carton
// - merge bit 15 enables override
// - merge bits 4-6 inhibit line release
// - merge bits 0-3 select release priority
// - motor clear held 500 ms resets
`include "zcrs_regs.vh"

module zcrs_core #(
  parameter        NZ             = 220,
  parameter [7:0]  LOCAL_US_ZONE  = 8'h00,
  parameter [24:0] FATAL_HOLD_CYC = `ZCRS_FATAL_HOLD_CYC
) (
  input  wire          i_clk,
  input  wire          i_sys_rst,
  input  wire          i_reg_wr,
  input  wire          i_reg_rd,
  input  wire [15:0]   i_reg_addr,
  input  wire [15:0]   i_reg_wdata,
  output reg  [15:0]   o_reg_rdata,
  input  wire [NZ-1:0] i_zone_blocked,
  output reg           o_stop_group_stopped,
  output reg           o_us_jam_clear_start,
  output reg           o_ds_jam_clear_start,
  output reg           o_fatal_reset,
  output reg  [NZ-1:0] o_zone_accum_en,
  output reg  [NZ-1:0] o_zone_hold,
  output reg  [NZ-1:0] o_zone_alt_release,
  output reg  [NZ-1:0] o_zone_reverse,
  output reg  [NZ-1:0] o_zone_maint,
  output reg           o_merge_override,
  output reg           o_merge_inh_center,
  output reg           o_merge_inh_left,
  output reg           o_merge_inh_right,
  output reg  [1:0]    o_merge_priority
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function [NZ-1:0] zone_mask;
    input [7:0] start;
    input [7:0] cnt;
    integer     k;
    begin
      zone_mask = {NZ{1'b0}};
      for (k = 0; k < NZ; k = k + 1) begin
        if (cnt == 8'h00) begin
          zone_mask[k] = 1'b1;
        end else if ((k >= start) && (k < start + cnt)) begin
          zone_mask[k] = 1'b1;
        end
      end
    end
  endfunction

  // only listed codes are acted on, others leave zones alone
  function mode_known;
    input [7:0] c;
    begin
      case (c)
        `ZCRS_MODE_NORMAL, `ZCRS_MODE_ACCUM_A, `ZCRS_MODE_ACCUM_B,
        `ZCRS_MODE_ALT_RELEASE, `ZCRS_MODE_DEF_RELEASE,
        `ZCRS_MODE_RUN_FWD, `ZCRS_MODE_RUN_REV, `ZCRS_MODE_MAINT,
        `ZCRS_MODE_DIR_DEFAULT, `ZCRS_MODE_DIR_OPPOSITE: begin
          mode_known = 1'b1;
        end
        default: begin
          mode_known = 1'b0;
        end
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // stored command words

  reg [15:0] stop_word_q;
  reg [15:0] mclr_word_q;
  reg [15:0] us_jam_word_q;
  reg [15:0] ds_jam_word_q;
  reg [15:0] us_mode_word_q;
  reg [15:0] ds_mode_word_q;
  reg [15:0] merge_word_q;

  wire wr_stop  = i_reg_wr && (i_reg_addr == `ZCRS_ADDR_STOP_GROUP);
  wire wr_mclr  = i_reg_wr && (i_reg_addr == `ZCRS_ADDR_MOTOR_ERR_CLEAR);
  wire wr_usjam = i_reg_wr && (i_reg_addr == `ZCRS_ADDR_US_JAM_CLEAR);
  wire wr_dsjam = i_reg_wr && (i_reg_addr == `ZCRS_ADDR_DS_JAM_CLEAR);
  wire wr_usmod = i_reg_wr && (i_reg_addr == `ZCRS_ADDR_US_FLOW_MODE);
  wire wr_dsmod = i_reg_wr && (i_reg_addr == `ZCRS_ADDR_DS_FLOW_MODE);
  wire wr_merge = i_reg_wr && (i_reg_addr == `ZCRS_ADDR_MERGE_OVERRIDE);

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      stop_word_q    <= `ZCRS_WORD_RESET;
      mclr_word_q    <= `ZCRS_WORD_RESET;
      us_jam_word_q  <= `ZCRS_WORD_RESET;
      ds_jam_word_q  <= `ZCRS_WORD_RESET;
      us_mode_word_q <= `ZCRS_WORD_RESET;
      ds_mode_word_q <= `ZCRS_WORD_RESET;
      merge_word_q   <= `ZCRS_WORD_RESET;
    end else begin
      if (wr_stop) begin
        stop_word_q <= i_reg_wdata;
      end
      if (wr_mclr) begin
        mclr_word_q <= i_reg_wdata;
      end
      if (wr_usjam) begin
        us_jam_word_q <= i_reg_wdata;
      end
      if (wr_dsjam) begin
        ds_jam_word_q <= i_reg_wdata;
      end
      if (wr_usmod) begin
        us_mode_word_q <= i_reg_wdata;
      end
      if (wr_dsmod) begin
        ds_mode_word_q <= i_reg_wdata;
      end
      if (wr_merge) begin
        merge_word_q <= i_reg_wdata;
      end
    end
  end

  // readback, one cycle after the read strobe; unmapped reads zero
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `ZCRS_ADDR_STOP_GROUP: begin
          o_reg_rdata <= stop_word_q;
        end
        `ZCRS_ADDR_MOTOR_ERR_CLEAR: begin
          o_reg_rdata <= mclr_word_q;
        end
        `ZCRS_ADDR_US_JAM_CLEAR: begin
          o_reg_rdata <= us_jam_word_q;
        end
        `ZCRS_ADDR_DS_JAM_CLEAR: begin
          o_reg_rdata <= ds_jam_word_q;
        end
        `ZCRS_ADDR_US_FLOW_MODE: begin
          o_reg_rdata <= us_mode_word_q;
        end
        `ZCRS_ADDR_DS_FLOW_MODE: begin
          o_reg_rdata <= ds_mode_word_q;
        end
        `ZCRS_ADDR_MERGE_OVERRIDE: begin
          o_reg_rdata <= merge_word_q;
        end
        default: begin
          o_reg_rdata <= 16'h0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stop group

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_stop_group_stopped <= 1'b0;
    end else if (wr_stop) begin
      if (i_reg_wdata == `ZCRS_STOP_ENTER) begin
        o_stop_group_stopped <= 1'b1;
      end else if (i_reg_wdata == `ZCRS_STOP_RELEASE) begin
        o_stop_group_stopped <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // jam clear: edge of the stored word, so a held 1 fires once

  reg us_jam_prev_q;
  reg ds_jam_prev_q;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      us_jam_prev_q        <= 1'b0;
      ds_jam_prev_q        <= 1'b0;
      o_us_jam_clear_start <= 1'b0;
      o_ds_jam_clear_start <= 1'b0;
    end else begin
      us_jam_prev_q        <= us_jam_word_q[`ZCRS_TRIG_BIT];
      ds_jam_prev_q        <= ds_jam_word_q[`ZCRS_TRIG_BIT];
      o_us_jam_clear_start <= us_jam_word_q[`ZCRS_TRIG_BIT] & ~us_jam_prev_q;
      o_ds_jam_clear_start <= ds_jam_word_q[`ZCRS_TRIG_BIT] & ~ds_jam_prev_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // remote fatal error reset; any drop of the bit restarts the count

  reg [24:0] mclr_cnt_q;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      mclr_cnt_q    <= 25'h000_0000;
      o_fatal_reset <= 1'b0;
    end else begin
      o_fatal_reset <= 1'b0;
      if (!mclr_word_q[`ZCRS_TRIG_BIT]) begin
        mclr_cnt_q <= 25'h000_0000;
      end else if (mclr_cnt_q < FATAL_HOLD_CYC) begin
        mclr_cnt_q <= mclr_cnt_q + 25'h000_0001;
        if (mclr_cnt_q == FATAL_HOLD_CYC - 25'h000_0001) begin
          o_fatal_reset <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // zone sensors cross in from the field

  reg [NZ-1:0] blk_meta_q;
  reg [NZ-1:0] blk_sync_q;
  reg [NZ-1:0] blk_prev_q;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      blk_meta_q <= {NZ{1'b0}};
      blk_sync_q <= {NZ{1'b0}};
      blk_prev_q <= {NZ{1'b0}};
    end else begin
      blk_meta_q <= i_zone_blocked;
      blk_sync_q <= blk_meta_q;
      blk_prev_q <= blk_sync_q;
    end
  end

  wire [NZ-1:0] blk_rise = blk_sync_q & ~blk_prev_q;
  wire [NZ-1:0] blk_fall = ~blk_sync_q & blk_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // flow mode commands; downstream write wins if both land together

  wire       mode_wr  = wr_usmod | wr_dsmod;
  wire [7:0] mode_cmd = i_reg_wdata[`ZCRS_MODE_CMD_LSB +: 8];
  wire [7:0] mode_cnt = i_reg_wdata[`ZCRS_MODE_CNT_LSB +: 8];
  wire [7:0] mode_org = wr_dsmod ? LOCAL_US_ZONE + 8'h01 : LOCAL_US_ZONE;
  wire [NZ-1:0] msk   = zone_mask(mode_org, mode_cnt);
  wire       mode_act = mode_wr && mode_known(mode_cmd);

  integer z;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_zone_accum_en    <= {NZ{1'b0}};
      o_zone_hold        <= {NZ{1'b0}};
      o_zone_alt_release <= {NZ{1'b0}};
      o_zone_reverse     <= {NZ{1'b0}};
      o_zone_maint       <= {NZ{1'b0}};
    end else begin
      for (z = 0; z < NZ; z = z + 1) begin
        // a held zone lets go once its carton leaves, then waits again
        if (o_zone_accum_en[z] && blk_rise[z]) begin
          o_zone_hold[z] <= 1'b1;
        end else if (blk_fall[z]) begin
          o_zone_hold[z] <= 1'b0;
        end
        if (mode_act && msk[z]) begin
          case (mode_cmd)
            `ZCRS_MODE_NORMAL: begin
              o_zone_accum_en[z] <= 1'b0;
              o_zone_hold[z]     <= 1'b0;
              o_zone_maint[z]    <= 1'b0;
            end
            `ZCRS_MODE_ACCUM_A, `ZCRS_MODE_ACCUM_B: begin
              // occupied zones are not held until a fresh arrival
              o_zone_accum_en[z] <= 1'b1;
              o_zone_hold[z]     <= 1'b0;
            end
            `ZCRS_MODE_ALT_RELEASE: begin
              o_zone_alt_release[z] <= 1'b1;
            end
            `ZCRS_MODE_DEF_RELEASE: begin
              o_zone_alt_release[z] <= 1'b0;
            end
            `ZCRS_MODE_RUN_FWD: begin
              o_zone_reverse[z] <= 1'b0;
            end
            `ZCRS_MODE_RUN_REV: begin
              o_zone_reverse[z] <= 1'b1;
            end
            `ZCRS_MODE_MAINT: begin
              o_zone_maint[z] <= 1'b1;
            end
            `ZCRS_MODE_DIR_DEFAULT: begin
              o_zone_reverse[z] <= 1'b0;
            end
            `ZCRS_MODE_DIR_OPPOSITE: begin
              o_zone_reverse[z] <= 1'b1;
            end
            default: begin
              o_zone_maint[z] <= o_zone_maint[z];
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // merge override; out-of-range priority keeps the last good one

  wire [3:0] prio_code = i_reg_wdata[`ZCRS_MERGE_PRIO_LSB +: 4];

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_merge_override   <= 1'b0;
      o_merge_inh_center <= 1'b0;
      o_merge_inh_left   <= 1'b0;
      o_merge_inh_right  <= 1'b0;
      o_merge_priority   <= 2'h0;
    end else if (wr_merge) begin
      o_merge_override   <= i_reg_wdata[`ZCRS_MERGE_EN_BIT];
      o_merge_inh_center <= i_reg_wdata[`ZCRS_MERGE_EN_BIT] &
                            i_reg_wdata[`ZCRS_MERGE_INH_CENTER_BIT];
      o_merge_inh_left   <= i_reg_wdata[`ZCRS_MERGE_EN_BIT] &
                            i_reg_wdata[`ZCRS_MERGE_INH_LEFT_BIT];
      o_merge_inh_right  <= i_reg_wdata[`ZCRS_MERGE_EN_BIT] &
                            i_reg_wdata[`ZCRS_MERGE_INH_RIGHT_BIT];
      if (!i_reg_wdata[`ZCRS_MERGE_EN_BIT]) begin
        o_merge_priority <= 2'h0;
      end else if (prio_code <= `ZCRS_MERGE_PRIO_MAX) begin
        o_merge_priority <= prio_code[1:0];
      end
    end
  end

endmodule

// ### src/zcrs_regs.vh
`ifndef ZCRS_REGS_VH
`define ZCRS_REGS_VH

// register word offsets on the fieldbus output image
`define ZCRS_ADDR_STOP_GROUP       16'h0014
`define ZCRS_ADDR_MOTOR_ERR_CLEAR  16'h0016
`define ZCRS_ADDR_US_JAM_CLEAR     16'h006d
`define ZCRS_ADDR_DS_JAM_CLEAR     16'h00bd
`define ZCRS_ADDR_US_FLOW_MODE     16'h016d
`define ZCRS_ADDR_DS_FLOW_MODE     16'h0177
`define ZCRS_ADDR_MERGE_OVERRIDE   16'h0183

`define ZCRS_WORD_RESET            16'h0000

// stop group command values
`define ZCRS_STOP_NONE             16'h0000
`define ZCRS_STOP_ENTER            16'h0001
`define ZCRS_STOP_RELEASE          16'h0002

// flow mode low byte commands
`define ZCRS_MODE_NORMAL           8'h00
`define ZCRS_MODE_ACCUM_A          8'h01
`define ZCRS_MODE_ACCUM_B          8'h02
`define ZCRS_MODE_ALT_RELEASE      8'h03
`define ZCRS_MODE_DEF_RELEASE      8'h04
`define ZCRS_MODE_RUN_FWD          8'h05
`define ZCRS_MODE_RUN_REV          8'h06
`define ZCRS_MODE_MAINT            8'h07
`define ZCRS_MODE_DIR_DEFAULT      8'h0a
`define ZCRS_MODE_DIR_OPPOSITE     8'h0b
`define ZCRS_MODE_CMD_LSB          0
`define ZCRS_MODE_CNT_LSB          8
`define ZCRS_MODE_CNT_MAX          220

// merge override field positions
`define ZCRS_MERGE_EN_BIT          15
`define ZCRS_MERGE_INH_CENTER_BIT  4
`define ZCRS_MERGE_INH_LEFT_BIT    5
`define ZCRS_MERGE_INH_RIGHT_BIT   6
`define ZCRS_MERGE_PRIO_LSB        0
`define ZCRS_MERGE_PRIO_MAX        4'h3

// jam clear and motor clear trigger bit
`define ZCRS_TRIG_BIT              0

// timing
`define ZCRS_CLK_HZ                40000000
`define ZCRS_FATAL_HOLD_MS         500
// 500 ms at 40 MHz, sized to the hold counter so nothing is cut silently
`define ZCRS_FATAL_HOLD_CYC        25'h131_2d00

`endif

// ### tb/zcrs_core_sva.sv
module zcrs_core_sva #(
  parameter NZ = 220
) (
  input wire          i_clk,
  input wire          i_sys_rst,
  input wire          i_reg_wr,
  input wire [15:0]   i_reg_addr,
  input wire [15:0]   i_reg_wdata,
  input wire          o_stop_group_stopped,
  input wire          o_us_jam_clear_start,
  input wire          o_fatal_reset,
  input wire [NZ-1:0] o_zone_reverse,
  input wire          o_merge_override,
  input wire          o_merge_inh_center,
  input wire          o_merge_inh_left,
  input wire          o_merge_inh_right,
  input wire [1:0]    o_merge_priority
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire       w_stop = i_reg_wr && i_reg_addr == 16'h0014;
  wire       w_mrg  = i_reg_wr && i_reg_addr == 16'h0183;
  wire       w_usj  = i_reg_wr && i_reg_addr == 16'h006d && i_reg_wdata[0];
  wire [1:0] wd_pri = i_reg_wdata[1:0];
  wire [2:0] wd_inh = i_reg_wdata[6:4];
  wire [2:0] inh    = {o_merge_inh_right, o_merge_inh_left, o_merge_inh_center};
  ////////////////////////////////////////////////////////////////
  a_stop_enter: assert property (w_stop && i_reg_wdata == 16'h0001 |=> o_stop_group_stopped)
    else $error("stop group not entered");
  a_stop_release: assert property (w_stop && i_reg_wdata == 16'h0002 |=> !o_stop_group_stopped)
    else $error("stop group not released");
  a_stop_ignore: assert property (w_stop && i_reg_wdata > 16'h0002 |=> $stable(o_stop_group_stopped))
    else $error("unlisted stop code acted");
  a_jam_cause: assert property (o_us_jam_clear_start |-> $past(w_usj, 2))
    else $error("jam clear start without rising write");
  a_jam_single: assert property (o_us_jam_clear_start |=> !o_us_jam_clear_start)
    else $error("jam clear start repeated");
  a_merge_off: assert property (w_mrg && !i_reg_wdata[15] |=> !o_merge_override && inh == 3'h0 && o_merge_priority == 2'h0)
    else $error("merge override not cleared");
  a_merge_on: assert property (w_mrg && i_reg_wdata[15] && i_reg_wdata[3:0] <= 4'h3 |=>
    o_merge_override && inh == $past(wd_inh) && o_merge_priority == $past(wd_pri))
    else $error("merge override fields wrong");
  a_mode_reverse: assert property (i_reg_wr && (i_reg_addr == 16'h016d || i_reg_addr == 16'h0177) &&
    i_reg_wdata[15:8] == 8'h00 && (i_reg_wdata[7:0] == 8'h06 || i_reg_wdata[7:0] == 8'h0b) |=> &o_zone_reverse)
    else $error("reverse not applied to all zones");
  a_fatal_single: assert property (o_fatal_reset |=> !o_fatal_reset [*3])
    else $error("fatal reset repeated");
  c_jam: cover property (o_us_jam_clear_start);
  c_fatal: cover property (o_fatal_reset);
  c_merge: cover property (w_mrg && i_reg_wdata[15]);
endmodule

bind zcrs_core zcrs_core_sva #(.NZ(NZ)) u_zcrs_core_sva (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .o_stop_group_stopped(o_stop_group_stopped), .o_us_jam_clear_start(o_us_jam_clear_start),
  .o_fatal_reset(o_fatal_reset), .o_zone_reverse(o_zone_reverse), .o_merge_override(o_merge_override),
  .o_merge_inh_center(o_merge_inh_center), .o_merge_inh_left(o_merge_inh_left),
  .o_merge_inh_right(o_merge_inh_right), .o_merge_priority(o_merge_priority));

// ### tb/zcrs_plc_model.sv
module zcrs_plc_model (
  input  wire logic        i_clk,
  output logic             o_reg_wr,
  output logic             o_reg_rd,
  output logic      [15:0] o_reg_addr,
  output logic      [15:0] o_reg_wdata,
  input  wire logic [15:0] i_reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 16'h0000;
    o_reg_wdata = 16'h0000;
  end
  // released lines show the inverse so a stale value never looks valid
  task wr_word(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_reg_wr <= 1'b1;
    o_reg_addr <= a;
    o_reg_wdata <= d;
    @(posedge i_clk);
    o_reg_wr <= 1'b0;
    o_reg_addr <= ~a;
    o_reg_wdata <= ~d;
  endtask
  task rd_word(input logic [15:0] a, output logic [15:0] d);
    @(posedge i_clk);
    o_reg_rd <= 1'b1;
    o_reg_addr <= a;
    @(posedge i_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
    #1;
    d = i_reg_rdata;
  endtask
endmodule

// ### tb/tb_top.sv
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin err_count++; $display("wrong value %s exp %h got %h", n, e, a); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam NZ = 8;
  localparam FH = 20;
  logic          i_clk, i_sys_rst, wr, rd, stp, us, ds, fr, mov, ic, il, ir;
  logic [15:0]   addr, wdata, rdata, w;
  logic [NZ-1:0] blk, acc, hld, alt, rev, mnt, e_acc, e_alt, e_rev, e_mnt;
  logic [1:0]    pri, e_pri;
  int            err_count, n_compared, cyc, n_us, n_ds, n_fr, seed, i, k, org;

  zcrs_plc_model u_zcrs_plc_model (.i_clk(i_clk), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
    .o_reg_wdata(wdata), .i_reg_rdata(rdata));
  zcrs_core #(.NZ(NZ), .FATAL_HOLD_CYC(FH)) u_zcrs_core (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_zone_blocked(blk),
    .o_stop_group_stopped(stp), .o_us_jam_clear_start(us), .o_ds_jam_clear_start(ds), .o_fatal_reset(fr),
    .o_zone_accum_en(acc), .o_zone_hold(hld), .o_zone_alt_release(alt), .o_zone_reverse(rev),
    .o_zone_maint(mnt), .o_merge_override(mov), .o_merge_inh_center(ic), .o_merge_inh_left(il),
    .o_merge_inh_right(ir), .o_merge_priority(pri));
  ////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    // an unknown pulse counts as one so it can never pass as zero
    n_us += (us !== 1'b0);
    n_ds += (ds !== 1'b0);
    n_fr += (fr !== 1'b0);
    if (cyc == 5000) begin
      err_count++;
      end_sim;
    end
  end
  ////////////////////////////////////////////////////////////////
  task end_sim;
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task put(input logic [15:0] a, input logic [15:0] d);
    u_zcrs_plc_model.wr_word(a, d);
    #1;
  endtask
  task stop(input logic [15:0] d, input logic e);
    put(16'h0014, d);
    `CHK("stopped", e, stp)
  endtask
  task jam(input logic [15:0] d, input int e);
    n_us = 0;
    n_ds = 0;
    put(w, d);
    repeat (3) @(posedge i_clk);
    #1;
    `CHK("jam", (w == 16'h006d) ? {e[7:0], 8'h00} : {8'h00, e[7:0]}, {n_us[7:0], n_ds[7:0]})
  endtask
  task mode(input logic [15:0] a, input logic [7:0] c, input logic [7:0] n);
    org = (a == 16'h0177);
    for (k = 0; k < NZ; k++) begin
      if (n == 0 || (k >= org && k < org + n)) begin
        case (c)
          0: {e_acc[k], e_mnt[k]} = 2'b00;
          1, 2: e_acc[k] = 1'b1;
          3, 4: e_alt[k] = (c == 3);
          5, 6, 10, 11: e_rev[k] = (c == 6 || c == 11);
          7: e_mnt[k] = 1'b1;
          default: ;
        endcase
      end
    end
    put(a, {n, c});
    `CHK("zones", {e_acc, e_alt, e_rev, e_mnt}, {acc, alt, rev, mnt})
  endtask
  task sens(input int z, input logic v);
    @(posedge i_clk);
    blk[z] <= v;
    repeat (5) @(posedge i_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    seed = 50370;
    i_sys_rst = 1'b1;
    blk = '0;
    {e_acc, e_alt, e_rev, e_mnt, e_pri} = '0;
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    #1;
    `CHK("reset", 0, {stp, acc, hld, alt, rev, mnt, mov, pri})
    stop(1, 1'b1);
    stop(5, 1'b1);
    u_zcrs_plc_model.rd_word(16'h0014, w);
    `CHK("readback", 16'h0005, w)
    stop(2, 1'b0);
    stop(3, 1'b0);
    stop(1, 1'b1);
    stop(0, 1'b1);
    stop(2, 1'b0);
    put(16'h0200, 16'hffff);
    u_zcrs_plc_model.rd_word(16'h0200, w);
    `CHK("unmapped", 16'h0000, w)
    // a rewrite of 1 or 3 without a zero in between must not fire again
    // requests stand in for a controller that has seen the jam flag
    for (i = 0; i < 2; i++) begin
      w = i ? 16'h00bd : 16'h006d;
      jam(1, 1);
      jam(1, 0);
      jam(3, 0);
      jam(0, 0);
      jam(1, 1);
    end
    for (i = 0; i < 26; i++)
      mode((i % 2) ? 16'h0177 : 16'h016d, i / 2, {$random(seed)} % 11);
    mode(16'h0177, 6, 0);
    mode(16'h016d, 11, 220);
    // zone 1 is already full when accumulation starts
    sens(1, 1'b1);
    mode(16'h016d, 1, 0);
    sens(0, 1'b1);
    `CHK("hold", 8'h01, hld)
    sens(1, 1'b0);
    sens(1, 1'b1);
    `CHK("hold", 8'h03, hld)
    sens(0, 1'b0);
    `CHK("hold", 8'h02, hld)
    mode(16'h016d, 0, 0);
    for (i = 0; i < 24; i++) begin
      w = $random(seed);
      if (w[15] && w[3:0] <= 4'h3)
        e_pri = w[1:0];
      else if (!w[15])
        e_pri = 2'h0;
      put(16'h0183, w);
      `CHK("merge", {w[15], w[15] & w[4], w[15] & w[5], w[15] & w[6], e_pri}, {mov, ic, il, ir, pri})
    end
    n_fr = 0;
    put(16'h0016, 1);
    repeat (FH - 4) @(posedge i_clk);
    put(16'h0016, 0);
    repeat (6) @(posedge i_clk);
    put(16'h0016, 1);
    repeat (FH + 4) @(posedge i_clk);
    #1;
    `CHK("fatal", 1, n_fr)
    put(16'h0016, 0);
    end_sim;
  end
endmodule
